/* src/eeprom_ctl_pkg.sv */
// shared constants and types for the two-wire target sequencer
// Notes on behaviour
// R1: reset brings control state and address tracking to a defined value with no pin of its own.
// R2: after the init interval the sequencer sits idle waiting for a start.
// R3: bus activity during the init interval is ignored; the controller waits it out.
// R4: without a clean power-up the controller runs the phase-adjust sequence first.
// R5: the controller moves data at least 0.3 us after each clock fall.
// R6: pulses of 130 ns or less on data or clock are rejected.
// R7: a write starts only after a whole byte of data and a stop right after its ack.
// R8: a start while a command is received aborts it and restarts address reception.
// R9: the controller runs the phase-adjust sequence before cancelling while data is held low.
// R10: after a cancel the controller uses a random read, not a current-address read.
// R11: phase adjust is start, nine clocks with data high, start, stop.
// R12: the init interval is a parameterised count of clock cycles after reset.
package eeprom_ctl_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int GLITCH_NS = 130;
    // reject width rounds down to cycles that fit inside it, plus one to exceed it
    localparam int GLITCH_CYC = GLITCH_NS / CLK_PERIOD_NS + 1;
    localparam int INIT_CYC_DEFAULT = 8000;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;
    localparam logic [7:0] ADDR_RESET = 8'h00;

    typedef enum {
        ST_INIT, ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_DATA, ST_READ, ST_IGNORE
    } seq_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } bus_event_t;

    typedef struct packed {
        logic pulse;
        logic [7:0] addr;
        logic [7:0] data;
    } write_req_t;
endpackage

/* src/eeprom_seq.sv */
// start/stop sequencer with power-on init, glitch filter and write trigger
module eeprom_seq
    import eeprom_ctl_pkg::*;
#(
    parameter int INIT_CYC = INIT_CYC_DEFAULT,
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT // arbitrary value
) (
    input wire logic clk_in, // 40 MHz clock
    input wire logic rst_in, // async reset, stands in for power-on-clear
    input wire logic scl_in, // serial clock pin
    input wire logic sda_in, // serial data pin level
    output logic sda_oe_n_out, // low while pulling data low
    output logic ready_out, // init interval over
    output write_req_t wr_out, // write cycle trigger with address and data
    output logic busy_out // command in progress
);
    logic [2:0] scl_s, sda_s;
    logic scl_f, sda_f, next_scl_f, next_sda_f;
    logic [3:0] scl_cnt, sda_cnt, next_scl_cnt, next_sda_cnt;
    bus_event_t ev;

    // three-stage synchronisers; stage 1 only feeds stage 2
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    // a level must hold past the reject width before the filter follows
    always_comb begin
        next_scl_f = scl_f;
        next_sda_f = sda_f;
        next_scl_cnt = 4'h0;
        next_sda_cnt = 4'h0;
        if (scl_s[1] == scl_s[2] && scl_s[2] != scl_f) begin
            next_scl_cnt = scl_cnt + 4'h1;
            if (scl_cnt == 4'(GLITCH_CYC - 1))
                next_scl_f = scl_s[2]; // R6
        end
        if (sda_s[1] == sda_s[2] && sda_s[2] != sda_f) begin
            next_sda_cnt = sda_cnt + 4'h1;
            if (sda_cnt == 4'(GLITCH_CYC - 1))
                next_sda_f = sda_s[2]; // R6
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_cnt <= 4'h0;
            sda_cnt <= 4'h0;
        end else begin
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            scl_cnt <= next_scl_cnt;
            sda_cnt <= next_sda_cnt;
        end
    end

    logic scl_d, sda_d;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    always_comb begin
        ev.start = scl_f && scl_d && sda_d && !sda_f;
        ev.stop = scl_f && scl_d && !sda_d && sda_f;
        ev.rise = scl_f && !scl_d;
        ev.fall = !scl_f && scl_d;
    end

    seq_state_t state, next_state;
    logic [$clog2(INIT_CYC+1)-1:0] init_cnt, next_init_cnt;
    logic [3:0] bitn, next_bitn;
    logic [7:0] shreg, next_shreg;
    logic [7:0] addr, next_addr;
    logic [7:0] wdata, next_wdata;
    logic acked, next_acked; // last event was the ack of a data byte
    logic have_data, next_have_data;
    logic rw, next_rw;
    logic drive, next_drive;
    logic bit_open, next_bit_open; // clock rose since the last fall or start
    logic next_ready, next_busy;
    write_req_t next_wr;

    always_comb begin
        next_state = state;
        next_init_cnt = init_cnt;
        next_bitn = bitn;
        next_shreg = shreg;
        next_addr = addr;
        next_wdata = wdata;
        next_acked = acked;
        next_have_data = have_data;
        next_rw = rw;
        next_drive = drive;
        next_bit_open = bit_open;
        next_wr = '0;
        next_wr.addr = addr;
        next_wr.data = wdata;
        if (state == ST_INIT) begin
            // bus events fall on deaf ears until the count runs out
            next_drive = 1'b0; // R3
            if (init_cnt == '0)
                next_state = ST_IDLE; // R2
            else
                next_init_cnt = init_cnt - 1'b1; // R12
        end else if (ev.start) begin
            // abort whatever was under way and look for an address again
            next_state = ST_DEVADDR; // R8
            next_bitn = 4'h0;
            next_drive = 1'b0;
            next_acked = 1'b0;
            next_have_data = 1'b0;
            next_bit_open = 1'b0;
        end else if (ev.stop) begin
            if (state == ST_DATA && acked && have_data)
                next_wr.pulse = 1'b1; // R7
            next_state = ST_IDLE;
            next_drive = 1'b0;
            next_acked = 1'b0;
            next_have_data = 1'b0;
        end else if (ev.rise && state != ST_IDLE && state != ST_IGNORE) begin
            next_bit_open = 1'b1;
            if (bitn <= BIT_LAST)
                next_shreg = {shreg[6:0], sda_f};
        end else if (ev.fall && bit_open && state != ST_IDLE
            && state != ST_IGNORE) begin
            // the fall that closes a start carries no bit
            next_bit_open = 1'b0;
            next_acked = 1'b0;
            if (bitn == BIT_LAST) begin
                next_bitn = BIT_ACK;
                unique case (state)
                    ST_DEVADDR: begin
                        next_drive = shreg[7:1] == DEV_ADDR;
                        next_rw = shreg[0];
                        if (shreg[7:1] != DEV_ADDR)
                            next_state = ST_IGNORE;
                    end
                    ST_WORDADDR: begin
                        next_addr = shreg;
                        next_drive = 1'b1;
                    end
                    ST_DATA: begin
                        next_wdata = shreg;
                        next_drive = 1'b1;
                    end
                    default: next_drive = 1'b0;
                endcase
            end else if (bitn == BIT_ACK) begin
                next_bitn = 4'h0;
                next_drive = 1'b0;
                unique case (state)
                    ST_DEVADDR: next_state = rw ? ST_READ : ST_WORDADDR;
                    ST_WORDADDR: next_state = ST_DATA;
                    ST_DATA: begin
                        next_acked = 1'b1; // R7
                        next_have_data = 1'b1;
                    end
                    default: next_state = state;
                endcase
            end else begin
                next_bitn = bitn + 4'h1;
            end
        end
        next_ready = next_state != ST_INIT;
        next_busy = next_state != ST_INIT && next_state != ST_IDLE;
    end

    // reset acts as power-on-clear for all tracking state
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_INIT; // R1
            init_cnt <= ($clog2(INIT_CYC+1))'(INIT_CYC);
            bitn <= 4'h0;
            shreg <= 8'h00;
            addr <= ADDR_RESET; // R1
            wdata <= 8'h00;
            acked <= 1'b0;
            have_data <= 1'b0;
            rw <= 1'b0;
            drive <= 1'b0;
            bit_open <= 1'b0;
            sda_oe_n_out <= 1'b1;
            ready_out <= 1'b0;
            busy_out <= 1'b0;
            wr_out <= '0;
        end else begin
            state <= next_state;
            init_cnt <= next_init_cnt;
            bitn <= next_bitn;
            shreg <= next_shreg;
            addr <= next_addr;
            wdata <= next_wdata;
            acked <= next_acked;
            have_data <= next_have_data;
            rw <= next_rw;
            drive <= next_drive;
            bit_open <= next_bit_open;
            // own flop so the pin never sees a gate after the register
            sda_oe_n_out <= ~next_drive;
            ready_out <= next_ready;
            busy_out <= next_busy;
            wr_out <= next_wr;
        end
    end


    // read data output is not part of this sequencer; reads only ack
    sequence start_seen_s;
        ev.start && state != ST_INIT;
    endsequence

    init_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_INIT |-> !wr_out.pulse && !drive) // R3
        else $error("bus answered during init");
    init_exit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_INIT && init_cnt == '0 |=> state == ST_IDLE) // R2
        else $error("init did not end in idle");
    init_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_INIT && init_cnt != '0 |=> $past(init_cnt) - 1'b1 == init_cnt) // R12
        else $error("init count did not step");
    start_abort_a: assert property (@(posedge clk_in) disable iff (rst_in)
        start_seen_s |=> state == ST_DEVADDR && bitn == 4'h0) // R8
        else $error("start did not restart address");
    write_cause_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_out.pulse |-> $past(ev.stop) && $past(state) == ST_DATA
            && $past(acked)) // R7
        else $error("write without stop after ack");
    glitch_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(scl_f) |-> $past(scl_cnt) == 4'(GLITCH_CYC - 1)) // R6
        else $error("clock filter moved early");
    sda_glitch_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(sda_f) |-> $past(sda_cnt) == 4'(GLITCH_CYC - 1)) // R6
        else $error("data filter moved early");
    ready_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ready_out |=> ready_out && state != ST_INIT) // R2
        else $error("ready dropped after init");
    start_fall_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ev.fall && !bit_open |=> bitn == $past(bitn)) // R8
        else $error("bit count moved without a bit");
endmodule

/* testbench/bus_ctl.sv */
// bus controller model driving the two-wire link
module bus_ctl (
    input wire logic clk_in, // bench clock, paces the link
    input wire logic sda_in, // resolved data line
    output logic scl_out, // serial clock
    output logic sda_out // data drive, 1 releases to the pull-up
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // clock high for 200 ns: 150 ns or less would fall inside the filter
    task automatic low_phase(input logic b);
        hold(12);
        sda_out = b;
        hold(4);
    endtask
    task automatic put_bit(input logic b, output logic s);
        low_phase(b);
        scl_out = 1'b1;
        hold(8);
        s = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic cond_start;
        low_phase(1'b1);
        scl_out = 1'b1;
        hold(8);
        sda_out = 1'b0;
        hold(8);
        scl_out = 1'b0;
    endtask
    // only after a clock fall, else the data drop reads as a start
    task automatic cond_stop;
        low_phase(1'b0);
        scl_out = 1'b1;
        hold(8);
        sda_out = 1'b1;
        hold(8);
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(v[i], s);
        put_bit(1'b1, ack);
    endtask
    // 100 ns dip while the clock is high
    task automatic glitch;
        sda_out = 1'b0;
        hold(4);
        sda_out = 1'b1;
        hold(8);
    endtask
    task automatic phase_adjust;
        logic s;
        cond_start;
        repeat (9) put_bit(1'b1, s);
        cond_start;
        cond_stop;
    endtask
endmodule

/* testbench/eeprom_seq_test.sv */
// self-checking bench for the two-wire target sequencer
module eeprom_seq_test import eeprom_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT = 400;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic scl, sda_m, sda_oe_n, ready, busy, ack;
    write_req_t wr;
    write_req_t last_wr = '0;
    int mismatches = 0;
    int tests_run = 0;
    int pulses = 0;
    int wait_cyc = 0;
    int busy_seen = 0;
    wire logic sda = sda_m & sda_oe_n; // open drain with pull-up
    always #12.5 clk_in = ~clk_in;
    bus_ctl bus (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_out(sda_m));
    eeprom_seq #(.INIT_CYC(INIT)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .scl_in(scl), .sda_in(sda), .sda_oe_n_out(sda_oe_n),
        .ready_out(ready), .wr_out(wr), .busy_out(busy));
    always @(posedge clk_in) begin
        if (wr.pulse === 1'b1) begin
            pulses <= pulses + 1;
            last_wr <= wr;
        end
        if (!rst_in && ready !== 1'b1) wait_cyc <= wait_cyc + 1;
        if (busy === 1'b1) busy_seen <= busy_seen + 1;
    end
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] v, input logic exp_ack);
        bus.put_byte(v, ack);
        check("ack", ack, exp_ack);
    endtask
    // pulse lands some 9 cycles after the stop, give it 16
    task automatic end_write(input int n, input logic [15:0] v);
        bus.cond_stop;
        bus.hold(16);
        check("pulses", 16'(pulses), 16'(n));
        check("write", {last_wr.addr, last_wr.data}, v);
        check("busy idle", busy, 1'b0);
    endtask
    task automatic test_init;
        check("oe reset", sda_oe_n, 1'b1);
        check("ready reset", ready, 1'b0);
        check("busy reset", busy, 1'b0);
        rst_in = 1'b0;
        bus.cond_start;
        xfer(8'hA0, 1'b1);
        end_write(0, 16'h0000);
        check("ready early", ready, 1'b0);
        for (int i = 0; i < INIT && ready !== 1'b1; i++) @(negedge clk_in);
        check("ready", ready, 1'b1);
        if (ready !== 1'b1) stop_test;
        check("init time", 16'(wait_cyc >= INIT && wait_cyc <= INIT + 2),
            16'h0001);
        $display("test_init done");
    endtask
    task automatic test_write;
        bus.cond_start;
        xfer(8'hA0, 1'b0);
        check("busy", busy, 1'b1);
        xfer(8'h3C, 1'b0);
        xfer(8'h5A, 1'b0);
        end_write(1, 16'h3C5A);
        // stop straight after the address byte writes nothing
        bus.cond_start;
        xfer(8'hA0, 1'b0);
        xfer(8'h7E, 1'b0);
        end_write(1, 16'h3C5A);
        $display("test_write done");
    endtask
    task automatic test_cancel;
        bus.cond_start;
        xfer(8'hA0, 1'b0);
        xfer(8'h3C, 1'b0);
        repeat (4) bus.put_bit(1'b0, ack);
        bus.cond_start;
        xfer(8'hA0, 1'b0);
        xfer(8'h12, 1'b0);
        xfer(8'hC3, 1'b0);
        end_write(2, 16'h12C3);
        // address may be lost after a cancel: dummy write, then read
        bus.cond_start;
        xfer(8'hA0, 1'b0);
        xfer(8'h12, 1'b0);
        bus.cond_start;
        xfer(8'hA1, 1'b0);
        end_write(2, 16'h12C3);
        $display("test_cancel done");
    endtask
    task automatic test_phase;
        int b0;
        bus.cond_start;
        xfer(8'hA0, 1'b0);
        xfer(8'h3C, 1'b0);
        xfer(8'h5A, 1'b0);
        bus.phase_adjust;
        bus.hold(16);
        check("pulses", 16'(pulses), 16'h0002);
        check("busy", busy, 1'b0);
        bus.cond_start;
        xfer(8'hAE, 1'b1);
        end_write(2, 16'h12C3);
        // a passed dip would read as start then stop: busy for a few cycles
        b0 = busy_seen;
        bus.glitch;
        bus.hold(8);
        check("glitch", busy, 1'b0);
        check("glitch busy", 16'(busy_seen - b0), 16'h0000);
        $display("test_phase done");
    endtask
    initial begin
        repeat (4) @(negedge clk_in);
        test_init;
        test_write;
        test_cancel;
        test_phase;
        stop_test;
    end
endmodule
